/* design/lfai_pkg.sv */
// constants, carriers and state layout of the line/framer alarm interrupt block
// assumes one 40 MHz clock and a classic wishbone master with 32-bit data
package lfai_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_SUMMARY_ONE    = 6'h14;
  localparam logic [5:0] IDX_SUMMARY_TWO    = 6'h15;
  localparam logic [5:0] IDX_LINE_STATUS    = 6'h16;
  localparam logic [5:0] IDX_LINE_MASK      = 6'h17;
  localparam logic [5:0] IDX_FRAMER_STATUS  = 6'h18;
  localparam logic [5:0] IDX_FRAMER_MASK    = 6'h19;
  localparam logic [5:0] IDX_CONFIG         = 6'h20;
  localparam logic [5:0] IDX_SIG_ENABLE     = 6'h21;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CFG_T1_MODE       = 0;
  localparam int unsigned CFG_INTERVAL_SEL  = 1;
  localparam int unsigned CFG_EXT_ZEROS     = 2;
  localparam int unsigned CFG_THRESH_LSB    = 4;
  localparam logic [7:0]  LINE_EVENT_BITS   = 8'h70;
  localparam logic [7:0]  FRAMER_EVENT_BITS = 8'hf0;
  localparam logic [7:0]  RST_MASK          = 8'h00;
  localparam logic [7:0]  RST_CONFIG        = 8'h01;
  localparam logic [7:0]  RST_SIG_ENABLE    = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ           = 40_000;
  localparam int unsigned LEVEL_LOW_MS      = 50;
  localparam int unsigned TICK_LONG_MS      = 1000;
  localparam int unsigned TICK_T1_US        = 42_000;
  localparam int unsigned TICK_E1_US        = 62_500;
  localparam int unsigned CHAN_T1_NS        = 5181;
  localparam int unsigned CHAN_E1_NS        = 3906;
  localparam int unsigned LEVEL_LOW_CYC     = LEVEL_LOW_MS * CLK_KHZ;
  localparam int unsigned TICK_LONG_CYC     = TICK_LONG_MS * CLK_KHZ;
  localparam int unsigned TICK_T1_CYC       = TICK_T1_US * CLK_KHZ / 1000;
  localparam int unsigned TICK_E1_CYC       = TICK_E1_US * CLK_KHZ / 1000;
  localparam logic [7:0]  CHAN_T1_CYC       = 8'(CHAN_T1_NS * CLK_KHZ / 1_000_000);
  localparam logic [7:0]  CHAN_E1_CYC       = 8'(CHAN_E1_NS * CLK_KHZ / 1_000_000);
  localparam logic [11:0] ZEROS_T1          = 12'd192;
  localparam logic [11:0] ZEROS_E1          = 12'd255;
  localparam logic [11:0] ZEROS_E1_EXT      = 12'd2048;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       carrier_absent;
    logic       over_current;
    logic       open_circuit;
    logic [3:0] rx_level;
  } lfai_line_ind_t;

  typedef struct packed {
    logic yellow_alarm;
    logic all_ones;
    logic loss_of_sync;
    logic jitter_trip;
  } lfai_framer_ind_t;

  typedef struct packed {
    lfai_line_ind_t line_s1;
    lfai_line_ind_t line_s2;
    logic           txclk_s1;
    logic           txclk_s2;
    logic           txclk_s3;
    logic [7:0]     cfg;
    logic [7:0]     mask1;
    logic [7:0]     mask2;
    logic [7:0]     sig_en;
    logic [7:0]     sig_prev;
    logic [7:0]     pend1;
    logic [7:0]     pend2;
    logic [7:0]     prev1;
    logic [7:0]     prev2;
    logic [25:0]    level_cnt;
    logic [25:0]    tick_cnt;
    logic [7:0]     txclk_cnt;
    logic [11:0]    zero_cnt;
    logic           level_low;
    logic           txclk_lost;
    logic           fr_carrier_loss;
    logic           ack;
    logic [7:0]     dat;
    logic           irq;
  } lfai_state_t;

endpackage

/* design/lfai_core.sv */
// status, mask and interrupt summary logic for line and framer alarms
// assumes framer indications and bit strobe on clk_i; line pins asynchronous
`timescale 1ns/1ps
module lfai_core
  import lfai_pkg::*;
#(
  parameter int unsigned LEVEL_LOW_CYCLES = LEVEL_LOW_CYC,
  parameter int unsigned TICK_LONG_CYCLES = TICK_LONG_CYC,
  parameter int unsigned TICK_T1_CYCLES   = TICK_T1_CYC,
  parameter int unsigned TICK_E1_CYCLES   = TICK_E1_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire lfai_line_ind_t   line_ind_i,
  input  wire logic             line_tx_clock_input_i,
  input  wire lfai_framer_ind_t framer_ind_i,
  input  wire logic             framer_rx_positive_input_i,
  input  wire logic             framer_rx_negative_input_i,
  input  wire logic             rx_bit_valid_i,
  input  wire logic [7:0]       signaling_state_i,
  input  wire logic [6:0]       other_status_pending_i,
  output logic                  irq_o
);

  // ---------------------------------------------------------------
  // register index from byte address
  // ---------------------------------------------------------------
  function automatic logic [5:0] lfai_index(input logic [7:0] adr);
    lfai_index = adr[7:2];
  endfunction

  lfai_state_t r;
  lfai_state_t n;

  logic        below;
  logic        tick;
  logic        sig_ev;
  logic        txclk_edge;
  logic        req;
  logic        rd;
  logic        wr;
  logic        clr1;
  logic        clr2;
  logic [5:0]  idx;
  logic [7:0]  cond1;
  logic [7:0]  cond2;
  logic [7:0]  set1;
  logic [7:0]  set2;
  logic [7:0]  stat1;
  logic [7:0]  stat2;
  logic [7:0]  sum1;
  logic [7:0]  sum2;
  logic [25:0] tick_len;
  logic [7:0]  chan_len;
  logic [11:0] zero_len;
  logic        t1;

  always_comb begin
    n = r;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    n.line_s1  = line_ind_i;
    n.line_s2  = r.line_s1;
    n.txclk_s1 = line_tx_clock_input_i;
    n.txclk_s2 = r.txclk_s1;
    n.txclk_s3 = r.txclk_s2;
    t1 = r.cfg[CFG_T1_MODE];

    // ---------------------------------------------------------------
    // input level under threshold
    // ---------------------------------------------------------------
    below = r.line_s2.rx_level > r.cfg[CFG_THRESH_LSB +: 4];
    if (!below) begin
      n.level_cnt = '0;
      n.level_low = 1'b0;
    end else if (r.level_cnt >= 26'(LEVEL_LOW_CYCLES - 1)) begin
      n.level_low = 1'b1;
    end else begin
      n.level_cnt = r.level_cnt + 26'd1;
    end

    // ---------------------------------------------------------------
    // counter update tick
    // ---------------------------------------------------------------
    if (!r.cfg[CFG_INTERVAL_SEL]) begin
      tick_len = 26'(TICK_LONG_CYCLES);
    end else if (t1) begin
      tick_len = 26'(TICK_T1_CYCLES);
    end else begin
      tick_len = 26'(TICK_E1_CYCLES);
    end
    tick = r.tick_cnt >= tick_len - 26'd1;
    n.tick_cnt = tick ? '0 : r.tick_cnt + 26'd1;

    // ---------------------------------------------------------------
    // transmit clock loss
    // ---------------------------------------------------------------
    chan_len = t1 ? CHAN_T1_CYC : CHAN_E1_CYC;
    txclk_edge = r.txclk_s2 ^ r.txclk_s3;
    if (txclk_edge) begin
      n.txclk_cnt  = '0;
      n.txclk_lost = 1'b0;
    end else if (r.txclk_cnt >= chan_len - 8'd1) begin
      n.txclk_lost = 1'b1;
    end else begin
      n.txclk_cnt = r.txclk_cnt + 8'd1;
    end

    // ---------------------------------------------------------------
    // framer carrier loss on zero runs
    // ---------------------------------------------------------------
    if (t1) begin
      zero_len = ZEROS_T1;
    end else if (r.cfg[CFG_EXT_ZEROS]) begin
      zero_len = ZEROS_E1_EXT;
    end else begin
      zero_len = ZEROS_E1;
    end
    if (rx_bit_valid_i) begin
      if (framer_rx_positive_input_i || framer_rx_negative_input_i) begin
        n.zero_cnt        = '0;
        n.fr_carrier_loss = 1'b0;
      end else if (r.zero_cnt >= zero_len - 12'd1) begin
        n.fr_carrier_loss = 1'b1;
      end else begin
        n.zero_cnt = r.zero_cnt + 12'd1;
      end
    end

    // ---------------------------------------------------------------
    // signaling change of state
    // ---------------------------------------------------------------
    n.sig_prev = signaling_state_i;
    sig_ev = |((signaling_state_i ^ r.sig_prev) & r.sig_en);

    // ---------------------------------------------------------------
    // conditions and their interrupt edges
    // ---------------------------------------------------------------
    cond1 = {r.level_low, 3'b000, r.line_s2.carrier_absent,
             r.line_s2.over_current, r.line_s2.open_circuit,
             r.txclk_lost};
    cond2 = {4'h0, framer_ind_i.yellow_alarm & t1,
             framer_ind_i.all_ones, r.fr_carrier_loss,
             framer_ind_i.loss_of_sync};
    n.prev1 = cond1;
    n.prev2 = cond2;
    set1 = (cond1 ^ r.prev1) & ~LINE_EVENT_BITS;
    set1[6] = tick;
    set1[5] = sig_ev;
    set1[4] = framer_ind_i.jitter_trip;
    set2 = cond2 & ~r.prev2 & ~FRAMER_EVENT_BITS;
    set2[7] = r.prev2[3] & ~cond2[3] & t1;
    set2[6] = r.prev2[2] & ~cond2[2];
    set2[5] = r.prev2[1] & ~cond2[1];
    set2[4] = r.prev2[0] & ~cond2[0];

    // ---------------------------------------------------------------
    // status views and summaries
    // ---------------------------------------------------------------
    stat1 = (r.pend1 & LINE_EVENT_BITS) | (cond1 & ~LINE_EVENT_BITS);
    stat2 = (r.pend2 & FRAMER_EVENT_BITS) | (cond2 & ~FRAMER_EVENT_BITS);
    sum1 = {other_status_pending_i[5:0], |(r.pend2 & r.mask2),
            |(r.pend1 & r.mask1)};
    sum2 = {7'h00, other_status_pending_i[6]};

    // ---------------------------------------------------------------
    // wishbone slave
    // ---------------------------------------------------------------
    idx  = lfai_index(wb_adr_i);
    req  = wb_cyc_i && wb_stb_i && !r.ack;
    rd   = req && !wb_we_i;
    wr   = req && wb_we_i && wb_sel_i[0];
    clr1 = rd && (idx == IDX_LINE_STATUS);
    clr2 = rd && (idx == IDX_FRAMER_STATUS);
    n.ack = req;
    n.dat = r.dat;
    if (rd) begin
      case (idx)
        IDX_SUMMARY_ONE:   n.dat = sum1;
        IDX_SUMMARY_TWO:   n.dat = sum2;
        IDX_LINE_STATUS:   n.dat = stat1;
        IDX_LINE_MASK:     n.dat = r.mask1;
        IDX_FRAMER_STATUS: n.dat = stat2;
        IDX_FRAMER_MASK:   n.dat = r.mask2;
        IDX_CONFIG:        n.dat = r.cfg;
        IDX_SIG_ENABLE:    n.dat = r.sig_en;
        default:           n.dat = 8'h00;
      endcase
    end
    if (wr) begin
      case (idx)
        IDX_LINE_MASK:   n.mask1  = wb_dat_i[7:0];
        IDX_FRAMER_MASK: n.mask2  = wb_dat_i[7:0];
        IDX_CONFIG:      n.cfg    = wb_dat_i[7:0];
        IDX_SIG_ENABLE:  n.sig_en = wb_dat_i[7:0];
        default:         n.cfg    = r.cfg;
      endcase
    end

    // latched bits clear on read, a new set wins
    n.pend1 = (r.pend1 & ~{8{clr1}}) | set1;
    n.pend2 = (r.pend2 & ~{8{clr2}}) | set2;
    n.irq   = |{sum1, sum2};
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r        <= '0;
      r.cfg    <= RST_CONFIG;
      r.mask1  <= RST_MASK;
      r.mask2  <= RST_MASK;
      r.sig_en <= RST_SIG_ENABLE;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = {24'h000000, r.dat};
  assign irq_o    = r.irq;

endmodule

/* tb/lfai_core_props.sv */
// assertions on bus answers, summaries and interrupt output of lfai_core
// assumes bound onto lfai_core, sees only its ports
`timescale 1ns/1ps
module lfai_core_props
  import lfai_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_o,
  input  wire logic             wb_ack_o,
  input  wire lfai_framer_ind_t framer_ind_i,
  input  wire logic [6:0]       other_status_pending_i,
  input  wire logic             irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd(logic [7:0] a); s_take ##0 (!wb_we_i && wb_adr_i == a); endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_hi0; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper read data not zero");
  property p_unm; s_rd(8'hfc) |=> wb_dat_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_sum1; s_rd(8'h50) |=> wb_dat_o[7:2] == $past(other_status_pending_i[5:0]); endproperty
  a_sum1: assert property (p_sum1) else $error("summary one wrong");
  property p_sum2; s_rd(8'h54) |=> wb_dat_o[7:0] == {7'h0, $past(other_status_pending_i[6])}; endproperty
  a_sum2: assert property (p_sum2) else $error("summary two wrong");
  property p_irq; other_status_pending_i != 7'h0 |=> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq low with summary set");
  property p_los; framer_ind_i.loss_of_sync [*2] ##0 s_rd(8'h60) |=> wb_dat_o[0]; endproperty
  a_los: assert property (p_los) else $error("loss of sync not shown");
  property p_rst; disable iff (1'b0) srst_i |=> !wb_ack_o && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind lfai_core lfai_core_props u_lfai_core_props (.*);

/* tb/lfai_host.sv */
// host model: classic wishbone single cycles
// assumes one clock shared with the block
`timescale 1ns/1ps
module lfai_host (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, w};
    wb_adr_o <= a;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    {wb_cyc_o, wb_stb_o} <= 2'b00;
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench of the line/framer alarm interrupt block
// assumes host model lfai_host and the bound checker
`timescale 1ns/1ps
`define CHK(nm, ex, s) begin num_checks++; if ((s) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, s); end end
module tb
  import lfai_pkg::*;
;
  logic             clk_i, cyc, stb, we, ack, irq;
  logic             srst_i = 1'b1, txc = 1'b0, txrun = 1'b1, rp = 1'b0, rn = 1'b0, rv = 1'b0;
  logic [7:0]       adr, e, m, rnd, sig = 8'h00, exp_q[$], msk_q[$];
  logic [3:0]       sel;
  logic [31:0]      dw, dr;
  logic [6:0]       osp = 7'h0;
  lfai_line_ind_t   li = '0;
  lfai_framer_ind_t fi = '0;
  int               error_cnt = 0, num_checks = 0, seed = 75926;
  lfai_host u_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw));
  lfai_core #(.LEVEL_LOW_CYCLES(20), .TICK_LONG_CYCLES(50), .TICK_T1_CYCLES(30), .TICK_E1_CYCLES(40))
  u_lfai_core (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .line_ind_i(li),
    .line_tx_clock_input_i(txc), .framer_ind_i(fi), .framer_rx_positive_input_i(rp),
    .framer_rx_negative_input_i(rn), .rx_bit_valid_i(rv), .signaling_state_i(sig),
    .other_status_pending_i(osp), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (txrun) txc <= ~txc;
  always @(negedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK($sformatf("rd %h", adr), e, dr[7:0] & m)
    end
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k);
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    u_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bits(input int n, input logic [1:0] v);
    repeat (n) begin
      @(posedge clk_i);
      {rp, rn, rv} <= {v, 1'b1};
    end
    @(posedge clk_i);
    rv <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    tk(10);
    srst_i <= 1'b0;
    rd(8'h5c, 8'h00, 8'hff);
    rd(8'h64, 8'h00, 8'hff);
    rd(8'h80, 8'h01, 8'hff);
    rnd = 8'($random(seed));
    wr(8'h5c, rnd);
    rd(8'h5c, rnd, 8'hff);
    wr(8'h5c, 8'h00);
    wr(8'h54, 8'hff);
    rd(8'hfc, 8'h00, 8'hff);
    osp <= 7'($random(seed));
    tk(2);
    rd(8'h50, {osp[5:0], 2'b00}, 8'hfc);
    rd(8'h54, {7'h0, osp[6]}, 8'hff);
    osp <= 7'h0;
    $display("test registers done");
    tk(60);
    rd(8'h58, 8'h40, 8'h40);
    wr(8'h5c, 8'h10);
    fi.jitter_trip <= 1'b1;
    tk(1);
    fi.jitter_trip <= 1'b0;
    tk(2);
    rd(8'h50, 8'h01, 8'h01);
    rd(8'h58, 8'h10, 8'h10);
    rd(8'h58, 8'h00, 8'h10);
    rd(8'h50, 8'h00, 8'h01);
    wr(8'h84, 8'h01);
    sig <= 8'h01;
    tk(2);
    rd(8'h58, 8'h20, 8'h20);
    $display("test events done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h5c, 8'h08 >> i);
      li[6-i] <= 1'b1;
      tk(8);
      rd(8'h58, 8'h08 >> i, 8'h08 >> i);
      rd(8'h50, 8'h00, 8'h01);
      li[6-i] <= 1'b0;
      tk(8);
      rd(8'h50, 8'h01, 8'h01);
      rd(8'h58, 8'h00, 8'h0e);
    end
    txrun <= 1'b0;
    tk(190);
    rd(8'h58, 8'h00, 8'h01);
    tk(30);
    rd(8'h58, 8'h01, 8'h01);
    txrun <= 1'b1;
    $display("test line conditions done");
    wr(8'h64, 8'h0d);
    fi <= 4'he;
    tk(2);
    rd(8'h50, 8'h02, 8'h02);
    rd(8'h60, 8'h0d, 8'hff);
    rd(8'h50, 8'h00, 8'h02);
    fi <= 4'h0;
    tk(2);
    rd(8'h50, 8'h00, 8'h02);
    rd(8'h60, 8'hd0, 8'hff);
    rd(8'h60, 8'h00, 8'hf0);
    bits(191, 2'b00);
    rd(8'h60, 8'h00, 8'h02);
    bits(1, 2'b00);
    rd(8'h60, 8'h02, 8'h02);
    bits(1, 2'b10);
    rd(8'h60, 8'h20, 8'h22);
    $display("test framer done");
    // ----------------------------------------------------------
    // e1 tick, yellow and zero runs
    // ----------------------------------------------------------
    wr(8'h64, 8'h00);
    wr(8'h80, 8'h02);
    wr(8'h5c, 8'h40);
    rd(8'h58, 8'h40, 8'h40);
    tk(2);
    @(posedge clk_i iff irq === 1'b1);
    rd(8'h58, 8'h40, 8'h40);
    tk(28);
    rd(8'h58, 8'h00, 8'h40);
    tk(5);
    rd(8'h58, 8'h40, 8'h40);
    fi.yellow_alarm <= 1'b1;
    tk(2);
    rd(8'h60, 8'h00, 8'h08);
    fi.yellow_alarm <= 1'b0;
    tk(2);
    rd(8'h60, 8'h00, 8'h80);
    bits(254, 2'b00);
    rd(8'h60, 8'h00, 8'h02);
    bits(1, 2'b00);
    rd(8'h60, 8'h02, 8'h02);
    wr(8'h80, 8'h06);
    bits(1, 2'b01);
    rd(8'h60, 8'h00, 8'h02);
    bits(2047, 2'b00);
    rd(8'h60, 8'h00, 8'h02);
    bits(1, 2'b00);
    rd(8'h60, 8'h02, 8'h02);
    $display("test e1 done");
    // ----------------------------------------------------------
    // input level under threshold
    // ----------------------------------------------------------
    wr(8'h80, 8'h51);
    wr(8'h5c, 8'h80);
    li.rx_level <= 4'h6;
    tk(10);
    rd(8'h58, 8'h00, 8'h80);
    tk(20);
    rd(8'h50, 8'h01, 8'h01);
    @(negedge clk_i);
    `CHK("irq", 1'b1, irq)
    rd(8'h58, 8'h80, 8'h80);
    li.rx_level <= 4'h5;
    tk(6);
    rd(8'h50, 8'h01, 8'h01);
    rd(8'h58, 8'h00, 8'h80);
    tk(2);
    @(negedge clk_i);
    `CHK("irq", 1'b0, irq)
    $display("test level done");
    tk(2);
    results();
  end
  initial begin
    tk(10000);
    error_cnt++;
    results();
  end
endmodule
